/* File: testbench/lsr_modem.sv */
// modem data set model driving the line adapter's interface pins
`timescale 1ns/1ns
module lsr_modem (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // request-to-send from the adapter, controls from the bench
  input wire logic i_rts,
  input wire logic i_hold_cts,
  input wire logic i_ring_req,
  // data set pins
  output logic o_dsr,
  output logic o_carrier,
  output logic o_cts,
  output logic o_ring,
  output logic o_rx_data
);
  logic [2:0] rts_pipe;
  // ----------------------------------------
  // pin behaviour
  // ----------------------------------------
  // a slow data set may never answer request-to-send: the bench holds it off
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rts_pipe <= 3'h0;
      o_dsr <= 1'b0;
      o_cts <= 1'b0;
      o_rx_data <= 1'b0;
    end else begin
      rts_pipe <= {rts_pipe[1:0], i_rts};
      o_dsr <= 1'b1;
      o_cts <= rts_pipe[2] & !i_hold_cts;
      // idle line pattern changes every cycle so no stale level is mistaken for data
      o_rx_data <= !o_rx_data;
    end
  end
  assign o_carrier = 1'b0;
  assign o_ring = i_ring_req;
endmodule // lsr_modem

/* File: testbench/tb_top.sv */
// self-checking bench for line status words, indicators and interrupt request
`timescale 1ns/1ns
module tb_top;
  localparam longint T_CYC = 100;
  localparam longint C_CYC = 60;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  lsr_pkg::lsr_sense_t sense_q = '0;
  lsr_pkg::lsr_events_t ev_q = '0;
  logic init = 1'b0, init_clear = 1'b0, init_tx = 1'b0, init_cont = 1'b0;
  logic [15:0] tcw = 16'h0000;
  logic [11:0] count = 12'h000;
  logic st_ready = 1'b1, four_wire = 1'b1, hold_cts = 1'b0, ring_req = 1'b0;
  logic st_valid, sense_ready, cs_halt, force_ones, irq, line_hold, rts;
  logic dsr, carrier, cts, ring, rx_data;
  logic [15:0] st_word, w;
  int failures = 0;
  int cmp_count = 0;
  lsr_pkg::lsr_events_t ev_tab[7];
  logic [15:0] exp_tab[7];
  always #4 i_clk_sys = !i_clk_sys;
  lsr_line_status #(.TIMEOUT_CYC(T_CYC), .CONTINUE_CYC(C_CYC)) i_dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_sense(sense_q),
    .i_init(init), .i_init_clear(init_clear), .i_init_transmit(init_tx),
    .i_init_continue(init_cont), .i_table_control(tcw), .o_status_valid(st_valid),
    .o_status_word(st_word), .i_status_ready(st_ready), .o_sense_ready(sense_ready),
    .i_ev(ev_q), .i_byte_count(count), .i_serdes(8'h5A), .o_cs_halt(cs_halt),
    .o_force_check_ones(force_ones), .o_irq(irq), .o_line_hold(line_hold),
    .i_dsr(dsr), .i_carrier(carrier), .i_cts(cts), .i_ring(ring),
    .i_rx_data(rx_data), .i_four_wire(four_wire), .o_rts(rts));
  lsr_modem i_modem (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_rts(rts), .i_hold_cts(hold_cts),
    .i_ring_req(ring_req), .o_dsr(dsr), .o_carrier(carrier), .o_cts(cts),
    .o_ring(ring), .o_rx_data(rx_data));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // request held until the buffer has room; word read settled, before the edge that pops it
  task automatic sense(input logic [1:0] s, input logic r, input logic en, input logic c,
                       output logic [15:0] word);
    int n;
    logic room;
    n = 0;
    room = 1'b0;
    @(posedge i_clk_sys);
    sense_q <= '{valid: 1'b1, sel: s, reset_ind: r, continue_timer: 1'b0,
                 enable: en, clear: c};
    do begin
      @(negedge i_clk_sys);
      room = sense_ready;
      @(posedge i_clk_sys);
      n++;
    end while (room !== 1'b1 && n < 20);
    sense_q.valid <= 1'b0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while (st_valid !== 1'b1 && n < 40);
    if (st_valid !== 1'b1) begin
      failures++;
      print_verdict();
    end
    word = st_word;
    @(posedge i_clk_sys);
  endtask
  task automatic pulse(input lsr_pkg::lsr_events_t ev);
    @(posedge i_clk_sys);
    ev_q <= ev;
    @(posedge i_clk_sys);
    ev_q <= '0;
    repeat (4) @(posedge i_clk_sys);
  endtask
  task automatic do_init(input logic c, input logic tx, input logic cont);
    @(posedge i_clk_sys);
    init <= 1'b1;
    init_clear <= c;
    init_tx <= tx;
    init_cont <= cont;
    @(posedge i_clk_sys);
    init <= 1'b0;
  endtask
  task automatic op_clear();
    sense(lsr_pkg::SEL_OPERATING, 1'b1, 1'b0, 1'b0, w);
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b0, w);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n;
    foreach (ev_tab[i]) ev_tab[i] = '0;
    ev_tab[0].chan_error = 1'b1;
    exp_tab[0] = 16'h8000;
    ev_tab[1].protect_violation = 1'b1;
    exp_tab[1] = 16'hC000;
    ev_tab[2].mem_parity = 1'b1;
    exp_tab[2] = 16'h0400;
    ev_tab[3].check_mismatch = 1'b1;
    exp_tab[3] = 16'h0200;
    ev_tab[4].overrun = 1'b1;
    exp_tab[4] = 16'h0100;
    ev_tab[5].end_char = 1'b1;
    ev_tab[5].pad_ones = 1'b1;
    exp_tab[5] = 16'h1000;
    ev_tab[6].table_zero = 1'b1;
    exp_tab[6] = 16'h0800;
    repeat (12) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b0, w);
    chk("op latched idle", w & lsr_pkg::OP_LATCH_MASK, 16'h0000);
    chk("op dsr", {15'h0000, w[lsr_pkg::OP_DSR]}, 16'h0001);
    chk("op carrier four wire", {15'h0000, w[lsr_pkg::OP_CARRIER]}, 16'h0001);
    four_wire <= 1'b0;
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b0, w);
    chk("op carrier two wire", {15'h0000, w[lsr_pkg::OP_CARRIER]}, 16'h0000);
    // each indicator: latched, interrupting as marked, kept across a plain sense, cleared by reset sense
    for (int i = 0; i < 7; i++) begin
      pulse(ev_tab[i]);
      // the end-character indicator waits for the pad character to be stored
      if (i == 5) begin
        chk("end held for pad", {15'h0000, irq}, 16'h0000);
        pulse('{char_tick: 1'b1, default: 1'b0});
      end
      chk("no forced ones in receive", {15'h0000, force_ones}, 16'h0000);
      chk("cs halt", {15'h0000, cs_halt}, {15'h0000, |(exp_tab[i] & 16'h9000)});
      chk("irq raised", {15'h0000, irq}, {15'h0000, |(exp_tab[i] & lsr_pkg::OP_IRQ_MASK)});
      sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b0, w);
      chk("op indicator", w & lsr_pkg::OP_LATCH_MASK, exp_tab[i]);
      sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b0, w);
      chk("op kept", w & lsr_pkg::OP_LATCH_MASK, exp_tab[i]);
      op_clear();
      chk("op cleared", w & lsr_pkg::OP_LATCH_MASK, 16'h0000);
      repeat (3) @(posedge i_clk_sys);
      chk("irq dropped", {15'h0000, irq}, 16'h0000);
    end
    // suppressed table complete still latches but does not interrupt
    tcw <= 16'h4000;
    pulse(ev_tab[6]);
    chk("irq suppressed done", {15'h0000, irq}, 16'h0000);
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b0, w);
    chk("op done latched", w & lsr_pkg::OP_LATCH_MASK, 16'h0800);
    op_clear();
    tcw <= 16'h0000;
    count <= 12'h123;
    sense(lsr_pkg::SEL_BYTE_COUNT, 1'b0, 1'b0, 1'b0, w);
    chk("byte count word", w, 16'hFEDC);
    sense(lsr_pkg::SEL_ILLEGAL, 1'b0, 1'b0, 1'b0, w);
    chk("illegal select", w, 16'h0000);
    sense(lsr_pkg::SEL_DIAGNOSTIC, 1'b0, 1'b0, 1'b0, w);
    chk("diag not cts", {15'h0000, w[lsr_pkg::DG_NOT_CTS]}, 16'h0001);
    chk("diag jumper", {15'h0000, w[lsr_pkg::DG_JUMPER]}, 16'h0001);
    // initialize without clear after one sync is refused
    do_init(1'b1, 1'b0, 1'b0);
    ev_q.sync_found <= 1'b0;
    pulse('{sync_found: 1'b1, default: 1'b0});
    do_init(1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge i_clk_sys);
    chk("irq reject", {15'h0000, irq}, 16'h0001);
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b0, w);
    chk("reject", w & 16'h0040, 16'h0040);
    // transmit with a data set that never answers: full and shortened limits
    hold_cts <= 1'b1;
    do_init(1'b1, 1'b1, 1'b0);
    op_clear();
    chk("rts raised", {15'h0000, rts}, 16'h0001);
    repeat (70) @(posedge i_clk_sys);
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b0, w);
    chk("no early timeout", w & 16'h2000, 16'h0000);
    repeat (40) @(posedge i_clk_sys);
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b0, w);
    chk("timeout", w & 16'h2000, 16'h2000);
    pulse(ev_tab[4]);
    chk("forced check ones", {15'h0000, force_ones}, 16'h0001);
    tcw <= 16'h1000;
    do_init(1'b1, 1'b1, 1'b1);
    op_clear();
    repeat (70) @(posedge i_clk_sys);
    chk("irq suppressed timeout", {15'h0000, irq}, 16'h0000);
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b0, w);
    chk("continue timeout", w & 16'h2000, 16'h2000);
    tcw <= 16'h0000;
    // adapter clear resets the word; ring then counts while enabled and idle
    pulse(ev_tab[0]);
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b0, 1'b1, w);
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b1, 1'b0, w);
    chk("clear resets op", w & lsr_pkg::OP_LATCH_MASK, 16'h0000);
    chk("line held", {15'h0000, line_hold}, 16'h0001);
    ring_req <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    ring_req <= 1'b0;
    sense(lsr_pkg::SEL_OPERATING, 1'b0, 1'b1, 1'b0, w);
    chk("ring end char", w & 16'h1000, 16'h1000);
    op_clear();
    // fill the status buffer with the reader stalled, then drain it
    st_ready <= 1'b0;
    @(posedge i_clk_sys);
    sense_q <= '{valid: 1'b1, sel: lsr_pkg::SEL_BYTE_COUNT, default: 1'b0};
    n = 0;
    repeat (8) begin
      @(negedge i_clk_sys);
      if (sense_q.valid === 1'b1 && sense_ready === 1'b1) n++;
      @(posedge i_clk_sys);
    end
    sense_q.valid <= 1'b0;
    chk("fifo accepted", 16'(n), 16'(lsr_pkg::FIFO_DEPTH));
    st_ready <= 1'b1;
    n = 0;
    repeat (8) begin
      @(negedge i_clk_sys);
      if (st_valid === 1'b1) begin
        n++;
        chk("drained word", st_word, 16'hFEDC);
      end
      @(posedge i_clk_sys);
    end
    chk("fifo drained", 16'(n), 16'(lsr_pkg::FIFO_DEPTH));
    print_verdict();
  end
endmodule // tb_top

/* File: verilog/lsr_fifo.sv */
// file: small flop-based fifo for sensed status words
`timescale 1ns/1ns
module lsr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } lsr_fifo_state_t;
  lsr_fifo_state_t st;
  lsr_fifo_state_t next_st;
  logic push;
  logic pop;
  assign o_ready = (st.count != (AW+1)'(DEPTH));
  assign o_valid = (st.count != '0);
  assign o_data = st.mem[st.rd];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = i_data;
      next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : AW'(st.wr + 1'b1);
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : AW'(st.rd + 1'b1);
    end
    next_st.count = (AW+1)'(st.count + {AW'(0), push} - {AW'(0), pop});
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end
endmodule // lsr_fifo

/* File: verilog/lsr_line_status.sv */
// file: line adapter status words, indicators, interrupt and cycle-steal halting
`timescale 1ns/1ns
module lsr_line_status #(
  parameter longint TIMEOUT_CYC = lsr_pkg::TIMEOUT_CYC,
  parameter longint CONTINUE_CYC = lsr_pkg::CONTINUE_CYC
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // processor commands
  input wire lsr_pkg::lsr_sense_t i_sense,
  input wire logic i_init,
  input wire logic i_init_clear,
  input wire logic i_init_transmit,
  input wire logic i_init_continue,
  input wire logic [15:0] i_table_control,
  output logic o_status_valid,
  output logic [15:0] o_status_word,
  input wire logic i_status_ready,
  output logic o_sense_ready,
  // core events from framing and cycle steal
  input wire lsr_pkg::lsr_events_t i_ev,
  input wire logic [11:0] i_byte_count,
  input wire logic [7:0] i_serdes,
  output logic o_cs_halt,
  output logic o_force_check_ones,
  output logic o_irq,
  output logic o_line_hold,
  // modem pins
  input wire logic i_dsr,
  input wire logic i_carrier,
  input wire logic i_cts,
  input wire logic i_ring,
  input wire logic i_rx_data,
  input wire logic i_four_wire,
  output logic o_rts
);
  localparam int TW = 29;
  localparam logic [TW-1:0] T3 = TW'(TIMEOUT_CYC - 1);
  localparam logic [TW-1:0] T2 = TW'(CONTINUE_CYC - 1);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    LSR_IDLE = 2'h0,
    LSR_HUNT = 2'h1,
    LSR_SYNCED = 2'h3,
    LSR_TURNED = 2'h2
  } lsr_line_t;
  typedef struct packed {
    lsr_line_t line;
    logic [15:0] op;
    logic [TW-1:0] timer;
    logic cont;
    logic transmit;
    logic enabled;
    logic initialized;
    logic irq_mask;
    logic [1:0] mask_cnt;
    logic char_trig;
    logic transparent;
    logic text;
    logic end_flag;
    logic end_pending;
    logic check_ones;
    logic irq;
    logic halt;
    logic rts;
    logic [2:0][4:0] sync1;
    logic [2:0][4:0] sync2;
  } lsr_state_t;
  lsr_state_t st;
  lsr_state_t next_st;
  logic [4:0] pins_s;
  logic dsr_s, car_s, cts_s, ring_s, rxd_s;
  logic fifo_ready;
  logic [15:0] word;
  logic [15:0] dg_word;
  logic turnaround;
  logic t_expired;
  logic [15:0] irq_mask;
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // only the second stage is read; the first may still be settling
  genvar g;
  for (g = 0; g < 5; g++) begin : g_sync
    assign pins_s[g] = st.sync2[0][g];
  end
  assign {dsr_s, car_s, cts_s, ring_s, rxd_s} = pins_s;
  assign turnaround = i_ev.end_char && (i_ev.pad_ones || !i_ev.in_text);
  // one timer serves both limits; continue only picks the shorter one
  assign t_expired = st.cont ? (st.timer >= T2) : (st.timer >= T3);
  always_comb begin
    dg_word = '0;
    dg_word[lsr_pkg::DG_JUMPER] = 1'b1;
    dg_word[lsr_pkg::DG_PHASE] = (st.line == LSR_SYNCED) || (st.line == LSR_TURNED);
    dg_word[lsr_pkg::DG_CHAR_TRIG] = st.char_trig;
    dg_word[lsr_pkg::DG_NOT_CTS] = !cts_s;
    dg_word[lsr_pkg::DG_TRANSPARENT] = st.transparent;
    dg_word[lsr_pkg::DG_TEXT] = st.text;
    dg_word[lsr_pkg::DG_END] = st.end_flag;
    dg_word[lsr_pkg::DG_RX_DATA] = rxd_s;
    dg_word[7:0] = i_serdes;
  end
  // ----------------------------------------
  // word selection and indicator logic
  // ----------------------------------------
  always_comb begin
    next_st = st;
    word = st.op;
    if (i_sense.sel == lsr_pkg::SEL_DIAGNOSTIC) begin
      word = dg_word;
    end else if (i_sense.sel == lsr_pkg::SEL_BYTE_COUNT) begin
      word = {lsr_pkg::BC_JUMPER_RESET, ~i_byte_count};
    end else if (i_sense.sel == lsr_pkg::SEL_ILLEGAL) begin
      word = '0;
    end
    next_st.sync1[0] = {i_dsr, i_carrier, i_cts, i_ring, i_rx_data};
    next_st.sync2[0] = st.sync1[0];
    next_st.op[lsr_pkg::OP_DSR] = dsr_s;
    next_st.op[lsr_pkg::OP_CARRIER] = i_four_wire || car_s;
    next_st.timer = TW'(st.timer + 1'b1);
    // clear latched indicators on reset sense; the clear below does so too
    if (i_sense.valid && fifo_ready && i_sense.sel == lsr_pkg::SEL_OPERATING
        && i_sense.reset_ind) begin
      next_st.op = next_st.op & ~lsr_pkg::OP_LATCH_MASK;
    end
    if (i_sense.valid && fifo_ready) begin
      if (i_sense.enable) begin
        next_st.enabled = 1'b1;
      end else begin
        next_st.enabled = 1'b0;
      end
      if (i_sense.continue_timer) begin
        next_st.cont = 1'b1;
        next_st.timer = '0;
      end
    end
    // clear resets word; any sense or initialize masks irq across command plus next
    if ((i_sense.valid && fifo_ready && i_sense.clear) || (i_init && i_init_clear)) begin
      next_st.op = next_st.op & ~lsr_pkg::OP_LATCH_MASK;
      next_st.transparent = 1'b0;
      next_st.text = 1'b0;
      next_st.end_flag = 1'b0;
      next_st.cont = 1'b0;
      next_st.check_ones = 1'b0;
      next_st.line = LSR_IDLE;
      next_st.initialized = 1'b0;
    end
    if (i_sense.valid || i_init) begin
      next_st.mask_cnt = 2'h2;
    end else if (st.mask_cnt != '0) begin
      next_st.mask_cnt = st.mask_cnt - 2'h1;
    end
    if (i_init) begin
      if (!i_init_clear && st.line == LSR_SYNCED) begin
        next_st.op[lsr_pkg::OP_REJECT] = 1'b1;
      end else begin
        next_st.initialized = 1'b1;
        next_st.line = LSR_HUNT;
        next_st.timer = '0;
        if (i_init_transmit != st.transmit) begin
          next_st.cont = 1'b0;
          next_st.text = 1'b0;
        end
        if (i_init_continue) begin
          next_st.cont = 1'b1;
        end
        next_st.transmit = i_init_transmit;
        next_st.rts = i_init_transmit;
      end
    end
    if (i_ev.protect_violation) begin
      next_st.op[lsr_pkg::OP_PROTECT] = 1'b1;
      next_st.op[lsr_pkg::OP_CHAN_STOP] = 1'b1;
    end
    if (i_ev.chan_error) begin
      next_st.op[lsr_pkg::OP_CHAN_STOP] = 1'b1;
    end
    if (st.line == LSR_HUNT && (i_ev.sync_found || (st.transmit && cts_s))) begin
      next_st.line = LSR_SYNCED;
      next_st.timer = '0;
    end else if (st.line == LSR_SYNCED && !i_ev.sync_fill && !st.transmit) begin
      next_st.timer = '0;
    end
    if (st.line != LSR_IDLE && t_expired && (st.line == LSR_HUNT || i_ev.sync_fill)) begin
      next_st.op[lsr_pkg::OP_TIMEOUT] = 1'b1;
      next_st.cont = 1'b0;
      next_st.timer = '0;
    end
    if (st.transmit && i_ev.table_zero && !i_ev.chaining && !i_ev.rx_table_started) begin
      next_st.op[lsr_pkg::OP_TIMEOUT] = 1'b1;
    end
    if (turnaround) begin
      next_st.end_pending = 1'b1;
      next_st.line = LSR_TURNED;
    end
    if (st.end_pending && i_ev.char_tick) begin
      next_st.op[lsr_pkg::OP_END_CHAR] = 1'b1;
      next_st.end_pending = 1'b0;
    end
    if (ring_s && st.enabled && !st.initialized) begin
      next_st.op[lsr_pkg::OP_END_CHAR] = 1'b1;
    end
    if (i_ev.table_zero) begin
      next_st.op[lsr_pkg::OP_TABLE_DONE] = 1'b1;
    end
    if (i_ev.mem_parity || i_ev.char_parity) begin
      next_st.op[lsr_pkg::OP_PARITY] = 1'b1;
      next_st.check_ones = next_st.check_ones | st.transmit;
    end
    if (i_ev.check_mismatch) begin
      next_st.op[lsr_pkg::OP_BLOCK_CHECK] = 1'b1;
    end
    if (i_ev.overrun) begin
      next_st.op[lsr_pkg::OP_OVERRUN] = 1'b1;
      next_st.check_ones = next_st.check_ones | st.transmit;
    end
    // char trigger toggles only in hunt, after turnaround or on phase sync
    if (st.line == LSR_HUNT || i_ev.phase_sync || st.line == LSR_TURNED) begin
      if (i_ev.char_tick) begin
        next_st.char_trig = !st.char_trig;
      end
    end else begin
      next_st.char_trig = 1'b0;
    end
    if (i_ev.dle_stx) begin
      next_st.transparent = 1'b1;
    end else if (i_ev.dle_end) begin
      next_st.transparent = 1'b0;
    end
    if (i_ev.text_start) begin
      next_st.text = 1'b1;
    end
    if (i_ev.end_seen && (i_ev.pad_ones || !i_ev.in_text)) begin
      next_st.end_flag = 1'b1;
    end
    // halt on end char or channel stop
    next_st.halt = next_st.op[lsr_pkg::OP_END_CHAR] || next_st.op[lsr_pkg::OP_CHAN_STOP];
    // suppression hides only the request; the indicators still latch for the reader
    irq_mask = lsr_pkg::OP_IRQ_MASK;
    if (i_table_control[lsr_pkg::TCW_SUPPRESS_DONE]) begin
      irq_mask[lsr_pkg::OP_TABLE_DONE] = 1'b0;
    end
    if (i_table_control[lsr_pkg::TCW_SUPPRESS_TIMEOUT]) begin
      irq_mask[lsr_pkg::OP_TIMEOUT] = 1'b0;
    end
    next_st.irq = (next_st.mask_cnt == '0) && |(next_st.op & irq_mask);
  end
  assign o_cs_halt = st.halt;
  assign o_force_check_ones = st.check_ones;
  assign o_irq = st.irq;
  assign o_line_hold = st.enabled;
  assign o_rts = st.rts;
  assign o_sense_ready = fifo_ready;
  // ----------------------------------------
  // sensed word fifo
  // ----------------------------------------
  // words queue so a slow reader never loses a sensed snapshot
  lsr_fifo #(
    .WIDTH(lsr_pkg::FIFO_WIDTH),
    .DEPTH(lsr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_valid(i_sense.valid),
    .i_data(word),
    .o_ready(fifo_ready),
    .o_valid(o_status_valid),
    .o_data(o_status_word),
    .i_ready(i_status_ready)
  );
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  protect_stop_a: assert property (i_ce && i_ev.protect_violation |=>
    st.op[lsr_pkg::OP_CHAN_STOP] && st.op[lsr_pkg::OP_PROTECT]) else $error("protect stop");
  halt_follow_a: assert property (i_ce && st.op[lsr_pkg::OP_END_CHAR] |-> o_cs_halt)
    else $error("no halt on end char");
  chan_halt_a: assert property (st.op[lsr_pkg::OP_CHAN_STOP] && i_ce |-> o_cs_halt)
    else $error("no halt on channel stop");
  keep_latch_a: assert property (i_ce && !i_sense.valid && !i_init &&
    st.op[lsr_pkg::OP_OVERRUN] |=> st.op[lsr_pkg::OP_OVERRUN]) else $error("latch lost");
  table_done_a: assert property (i_ce && i_ev.table_zero |=>
    st.op[lsr_pkg::OP_TABLE_DONE]) else $error("table done missing");
  parity_set_a: assert property (i_ce && i_ev.mem_parity |=> st.op[lsr_pkg::OP_PARITY])
    else $error("parity missing");
  check_err_a: assert property (i_ce && i_ev.check_mismatch |=>
    st.op[lsr_pkg::OP_BLOCK_CHECK]) else $error("check error missing");
  overrun_ones_a: assert property (i_ce && i_ev.overrun && st.transmit |=>
    o_force_check_ones) else $error("overrun no ones");
  irq_mask_a: assert property (i_ce && (i_sense.valid || i_init) |=> !o_irq)
    else $error("irq during command");
  cov_turn_c: cover property (turnaround ##[1:20] st.op[lsr_pkg::OP_END_CHAR]);
  cov_reset_c: cover property (i_sense.valid && i_sense.reset_ind);
  cov_reject_c: cover property (st.op[lsr_pkg::OP_REJECT]);
  cov_ring_c: cover property (ring_s && st.enabled && !st.initialized);
  cov_timeout_c: cover property (st.line == LSR_HUNT && t_expired);
  reject_set_a: assert property (i_ce && i_init && !i_init_clear &&
    st.line == LSR_SYNCED |=> st.op[lsr_pkg::OP_REJECT]) else $error("reject missing");
  ring_end_a: assert property (i_ce && ring_s && st.enabled && !st.initialized |=>
    st.op[lsr_pkg::OP_END_CHAR]) else $error("ring not latched");
  timeout_set_a: assert property (i_ce && st.line == LSR_HUNT && t_expired |=>
    st.op[lsr_pkg::OP_TIMEOUT]) else $error("timeout missing");
  dsr_follow_a: assert property (i_ce |=> st.op[lsr_pkg::OP_DSR] == $past(dsr_s))
    else $error("dsr not followed");
  parity_ones_a: assert property (i_ce && i_ev.char_parity && st.transmit |=>
    o_force_check_ones) else $error("parity no ones");
  illegal_sel_a: assert property (i_sense.sel == lsr_pkg::SEL_ILLEGAL |-> word == '0)
    else $error("illegal select not zero");
  end_flag_a: assert property (i_ce && i_ev.end_seen && !i_ev.in_text |=> st.end_flag)
    else $error("end flag missing");
endmodule // lsr_line_status

/* File: verilog/lsr_pkg.sv */
// package: status word layouts, command codes and timing constants for line status reporting
package lsr_pkg;
  // ----------------------------------------
  // status word select codes (modifier bits 13..14)
  // ----------------------------------------
  localparam logic [1:0] SEL_OPERATING = 2'h0;
  localparam logic [1:0] SEL_DIAGNOSTIC = 2'h1;
  localparam logic [1:0] SEL_BYTE_COUNT = 2'h2;
  localparam logic [1:0] SEL_ILLEGAL = 2'h3;
  // ----------------------------------------
  // operating status word bit positions (bit 0 is the msb)
  // ----------------------------------------
  localparam int OP_CHAN_STOP = 15;
  localparam int OP_PROTECT = 14;
  localparam int OP_TIMEOUT = 13;
  localparam int OP_END_CHAR = 12;
  localparam int OP_TABLE_DONE = 11;
  localparam int OP_PARITY = 10;
  localparam int OP_BLOCK_CHECK = 9;
  localparam int OP_OVERRUN = 8;
  localparam int OP_DSR = 7;
  localparam int OP_REJECT = 6;
  localparam int OP_CARRIER = 5;
  // latched indicators: bits 0-7 and bit 9
  localparam logic [15:0] OP_LATCH_MASK = 16'hFF40;
  // indicators that raise the interrupt request
  localparam logic [15:0] OP_IRQ_MASK = 16'hFA40;
  // ----------------------------------------
  // diagnostic word bit positions and jumpers
  // ----------------------------------------
  localparam int DG_JUMPER = 15;
  localparam int DG_PHASE = 14;
  localparam int DG_CHAR_TRIG = 13;
  localparam int DG_NOT_CTS = 12;
  localparam int DG_TRANSPARENT = 11;
  localparam int DG_TEXT = 10;
  localparam int DG_END = 9;
  localparam int DG_RX_DATA = 8;
  localparam logic [3:0] BC_JUMPER_RESET = 4'hF;
  // ----------------------------------------
  // table control word bits (bit 0 is the msb)
  // ----------------------------------------
  localparam int TCW_SUPPRESS_DONE = 14;
  localparam int TCW_SUPPRESS_TIMEOUT = 12;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam longint CLK_HZ = 125000000;
  localparam longint TIMEOUT_S = 3;
  localparam longint CONTINUE_S = 2;
  localparam longint TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  localparam longint CONTINUE_CYC = CONTINUE_S * CLK_HZ;
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 4;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [1:0] sel;
    logic reset_ind;
    logic continue_timer;
    logic enable;
    logic clear;
  } lsr_sense_t;
  typedef struct packed {
    logic chan_error;
    logic protect_violation;
    logic sync_found;
    logic sync_fill;
    logic end_char;
    logic pad_ones;
    logic in_text;
    logic table_zero;
    logic chaining;
    logic rx_table_started;
    logic mem_parity;
    logic char_parity;
    logic check_mismatch;
    logic overrun;
    logic char_tick;
    logic phase_sync;
    logic dle_stx;
    logic dle_end;
    logic text_start;
    logic end_seen;
  } lsr_events_t;
endpackage
